/* File: core/fifo_read_port.sv */
// read-side control of a deep fifo: reads, offset readback, rewind, serial offset load
// assumes all pin inputs are asynchronous to ref_clk_in and are synchronised here;
// strobe, read clock and serial clock arrive as sampled levels with edges detected
`timescale 1ns/1ps
`include "fifo_rd_regs.svh"
module fifo_read_port #(
  parameter int DEPTH_LOG2 = `DEPTH_LOG2
) (
  // clock and resets
  input  wire logic                    ref_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    master_reset_n_in,
  input  wire logic                    partial_reset_n_in,
  // configuration straps caught during master reset
  input  wire logic                    first_word_fallthrough_mode_in,
  input  wire logic [1:0]              out_width_in,
  input  wire logic                    async_read_in,
  // read port pins
  input  wire logic                    read_clk_in,
  input  wire logic                    read_enable_n_in,
  input  wire logic                    read_select_n_in,
  input  wire logic                    output_enable_n_in,
  input  wire logic                    rewind_n_in,
  input  wire logic                    mark_in,
  input  wire logic                    offset_access_n_in,
  // serial offset load
  input  wire logic                    serial_clk_in,
  input  wire logic                    serial_load_enable_n_in,
  input  wire logic                    serial_in,
  // memory side: word supply from the write side, with write pointer
  input  wire logic [`DATA_W-1:0]      mem_data_in,
  input  wire logic [DEPTH_LOG2-1:0]   write_ptr_in,
  output logic      [DEPTH_LOG2-1:0]   read_ptr_out,
  output logic                         write_ptr_clear_out,
  // data out with two-entry buffer
  input  wire logic                    data_ready_in,
  output logic                         data_valid_out,
  output logic      [`DATA_W-1:0]      read_data_out,
  output logic      [`DATA_W-1:0]      read_data_oe_out,
  // flags
  output logic                         empty_flag_n_out,
  output logic                         first_word_fallthrough_mode_mode_out
);
  // two-flop synchronisers for every pin; stage one feeds only stage two
  localparam int NS = 16;
  logic [NS-1:0] sync1, sync2, prev;
  wire  [NS-1:0] pins = {master_reset_n_in, partial_reset_n_in, read_clk_in,
                         read_enable_n_in, read_select_n_in, output_enable_n_in,
                         rewind_n_in, mark_in, offset_access_n_in, serial_clk_in,
                         serial_load_enable_n_in, serial_in, async_read_in,
                         first_word_fallthrough_mode_in, out_width_in};
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end
  wire mrs_n  = sync2[15];
  wire prs_n  = sync2[14];
  wire rclk_rise = sync2[13] & ~prev[13];
  wire ren_n  = sync2[12];
  wire rcs_n  = sync2[11];
  wire oe_n   = sync2[10];
  wire rt_n   = sync2[9];
  wire mark   = sync2[8];
  wire ld_n   = sync2[7];
  wire sclk_rise = sync2[6] & ~prev[6];
  wire sen_n  = sync2[5];
  wire si     = sync2[4];
  wire async_rd = sync2[3];
  wire in_reset = ~mrs_n | ~prs_n;

  // mode latched while master reset is low; partial reset leaves it alone
  logic first_word_fallthrough_mode;
  fifo_rd_pkg::out_width_e width;
  logic async_mode;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_word_fallthrough_mode       <= 1'b0;
      width      <= fifo_rd_pkg::bus_w36;
      async_mode <= 1'b0;
    end else if (!mrs_n) begin
      first_word_fallthrough_mode       <= sync2[2];
      width      <= fifo_rd_pkg::out_width_e'(sync2[1:0]);
      async_mode <= async_rd;
    end
  end

  // a read happens on an enabled, selected clock rise, or any selected strobe rise in async mode
  wire rd_edge = rclk_rise & (async_mode | ~ren_n) & ~rcs_n & ~in_reset;
  wire offset_rd = rd_edge & ~ld_n & ~async_mode;
  wire mem_empty = (read_ptr_out == write_ptr_in);
  logic [1:0] buf_cnt;
  wire buf_room = (buf_cnt != 2'h2);
  wire mem_rd   = rd_edge & ld_n & ~mem_empty & buf_room;
  wire rewind   = rclk_rise & ~rt_n & ~in_reset;

  function automatic logic [DEPTH_LOG2-1:0] ptr_inc(input logic [DEPTH_LOG2-1:0] p);
    ptr_inc = p + 1'b1; // natural wrap after last location
  endfunction

  // mark register: captured pointer and whether it is set
  logic [DEPTH_LOG2-1:0] mark_ptr;
  logic                  mark_set;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mark_ptr <= '0;
      mark_set <= 1'b0;
    end else if (in_reset) begin
      mark_set <= 1'b0;
    end else if (mark) begin
      mark_ptr <= read_ptr_out;
      mark_set <= 1'b1;
    end
  end

  // read pointer
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      read_ptr_out <= '0;
    end else if (in_reset) begin
      read_ptr_out <= '0;
    end else if (rewind) begin
      read_ptr_out <= mark_set ? mark_ptr : '0;
    end else if (mem_rd) begin
      read_ptr_out <= ptr_inc(read_ptr_out);
    end
  end

  // write pointer clear request to the write side during either reset
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) write_ptr_clear_out <= 1'b1;
    else           write_ptr_clear_out <= in_reset;
  end

  // offset registers: serial load shifts, kept across partial reset
  logic [2*`OFFSET_W-1:0] offsets;
  logic                   offset_sel;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      offsets <= {`OFFSET_FULL_RST, `OFFSET_EMPTY_RST};
    end else if (!mrs_n) begin
      offsets <= {`OFFSET_FULL_RST, `OFFSET_EMPTY_RST};
    end else if (sclk_rise & ~sen_n) begin
      offsets <= {offsets[2*`OFFSET_W-2:0], si};
    end
  end
  // offset readback alternates empty then full offset
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)      offset_sel <= 1'b0;
    else if (in_reset)  offset_sel <= 1'b0;
    else if (offset_rd) offset_sel <= ~offset_sel;
  end

  function automatic logic [`DATA_W-1:0] width_mask(input fifo_rd_pkg::out_width_e w);
    case (w)
      fifo_rd_pkg::bus_w18: width_mask = 36'h00003FFFF;
      fifo_rd_pkg::bus_w9:  width_mask = 36'h0000001FF;
      default:              width_mask = 36'hFFFFFFFFF;
    endcase
  endfunction

  // two-entry buffer between the read edge and the output register
  logic [`DATA_W-1:0] buf_q [2];
  logic               wr_idx, rd_idx;
  wire [`DATA_W-1:0]  item = offset_rd ?
      {18'h00000, offset_sel ? offsets[2*`OFFSET_W-1:`OFFSET_W] : offsets[`OFFSET_W-1:0]}
      : mem_data_in;
  wire push = mem_rd | (offset_rd & buf_room);
  wire pop  = data_valid_out & data_ready_in;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      buf_cnt <= 2'h0;
      wr_idx  <= 1'b0;
      rd_idx  <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (in_reset | rewind) begin
      buf_cnt <= 2'h0;
      wr_idx  <= 1'b0;
      rd_idx  <= 1'b0;
    end else begin
      if (push) begin
        buf_q[wr_idx] <= item & width_mask(width);
        wr_idx <= ~wr_idx;
      end
      if (pop && buf_cnt != 2'h0) rd_idx <= ~rd_idx;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop && buf_cnt != 2'h0};
    end
  end

  // output register, cleared by either reset
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      read_data_out  <= `OUT_RESET;
      data_valid_out <= 1'b0;
    end else if (in_reset) begin
      read_data_out  <= `OUT_RESET;
      data_valid_out <= 1'b0;
    end else if (rewind) begin
      data_valid_out <= 1'b0;
    end else if (!data_valid_out) begin
      data_valid_out <= (buf_cnt != 2'h0);
      if (buf_cnt != 2'h0) read_data_out <= buf_q[rd_idx];
    end else if (data_ready_in) begin // head taken: show the other entry, never the same one
      data_valid_out <= (buf_cnt == 2'h2);
      if (buf_cnt == 2'h2) read_data_out <= buf_q[~rd_idx];
    end
  end

  // drive: enable pin alone during reset, else enable and sampled select
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) read_data_oe_out <= '0;
    else read_data_oe_out <= (~oe_n & (in_reset | ~rcs_n)) ?
                             width_mask(width) : '0;
  end

  // flags
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      empty_flag_n_out <= 1'b0;
      first_word_fallthrough_mode_mode_out    <= 1'b0;
    end else begin
      empty_flag_n_out <= ~(in_reset | rewind | mem_empty);
      first_word_fallthrough_mode_mode_out    <= first_word_fallthrough_mode;
    end
  end

  // assertions
  property p_reset_clears;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      in_reset |=> (read_ptr_out == '0 && read_data_out == '0);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left state");
  property p_prs_keeps;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (mrs_n && !prs_n) |=> (first_word_fallthrough_mode == $past(first_word_fallthrough_mode) && offsets == $past(offsets));
  endproperty
  a_prs_keeps: assert property (p_prs_keeps) else $error("partial reset lost mode");
  property p_empty_no_move;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (rd_edge && mem_empty && !rewind) |=> $stable(read_ptr_out);
  endproperty
  a_empty_no_move: assert property (p_empty_no_move) else $error("read on empty");
  property p_advance;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (mem_rd && !rewind && !in_reset) |=> read_ptr_out == ptr_inc($past(read_ptr_out));
  endproperty
  a_advance: assert property (p_advance) else $error("pointer not advanced");
  property p_rewind;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      rewind |=> (read_ptr_out == ($past(mark_set) ? $past(mark_ptr) : '0) && !empty_flag_n_out);
  endproperty
  a_rewind: assert property (p_rewind) else $error("rewind target wrong");
  property p_mark;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (mark && !in_reset) |=> (mark_set && mark_ptr == $past(read_ptr_out));
  endproperty
  a_mark: assert property (p_mark) else $error("mark not captured");
  property p_serial;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (sclk_rise && sen_n && mrs_n) |=> $stable(offsets);
  endproperty
  a_serial: assert property (p_serial) else $error("shift while disabled");
  property p_drive_reset;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (in_reset && !oe_n) |=> read_data_oe_out != '0;
  endproperty
  a_drive_reset: assert property (p_drive_reset) else $error("no drive in reset");
  c_mem_read:   cover property (@(posedge ref_clk_in) mem_rd);
  c_offset_rd:  cover property (@(posedge ref_clk_in) offset_rd);
  c_rewind_mk:  cover property (@(posedge ref_clk_in) rewind && mark_set);
  c_buf_full:   cover property (@(posedge ref_clk_in) buf_cnt == 2'h2);
endmodule

/* File: core/fifo_rd_regs.svh */
// register-free constants for the fifo read port: widths, reset values, offsets
// assumes inclusion by core design files and test files
`ifndef FIFO_RD_REGS_SVH
`define FIFO_RD_REGS_SVH
`define DATA_W          36
`define OFFSET_W        18
`define DEPTH_LOG2      4
`define OUT_RESET       36'h000000000
`define OFFSET_EMPTY_RST 18'h0007F
`define OFFSET_FULL_RST  18'h0007F
`define WIDTH_36        2'h0
`define WIDTH_18        2'h1
`define WIDTH_9         2'h2
`define SYNC_STAGES     2
`endif

/* File: core/fifo_rd_pkg.sv */
// types shared by the fifo read port
// assumes the constants header is included where widths are needed
package fifo_rd_pkg;
  typedef enum logic [1:0] {
    bus_w36 = 2'h0,
    bus_w18 = 2'h1,
    bus_w9  = 2'h2
  } out_width_e;
  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_read = 3'h2,
    st_rew  = 3'h4
  } rd_state_e;
endpackage

/* File: test/word_store_model.sv */
// word store and write side standing behind the read port
// assumes the bench pushes words; the port reads combinationally at its pointer
`timescale 1ns/1ps
`include "fifo_rd_regs.svh"
module word_store_model #(
  parameter int DEPTH_LOG2 = 4
) (
  // clock and pointer clear
  input  wire logic                  ref_clk_in,
  input  wire logic                  clear_in,
  // pushes from the bench
  input  wire logic                  push_in,
  input  wire logic [`DATA_W-1:0]    push_data_in,
  // read side
  input  wire logic [DEPTH_LOG2-1:0] read_ptr_in,
  output logic      [`DATA_W-1:0]    mem_data_out,
  output logic      [DEPTH_LOG2-1:0] write_ptr_out
);
  logic [`DATA_W-1:0] store [2**DEPTH_LOG2];
  // a clear from either reset wins over a push, so no word lands mid-reset
  always_ff @(posedge ref_clk_in) begin
    if (clear_in) begin
      write_ptr_out <= '0;
    end else if (push_in) begin
      store[write_ptr_out] <= push_data_in;
      write_ptr_out        <= write_ptr_out + 1'b1; // wraps past the last slot
    end
  end
  assign mem_data_out = store[read_ptr_in];
endmodule

/* File: test/tb.sv */
// bench for the fifo read port: pin-level reads, rewind, resets, offsets
// assumes the word store model supplies memory and the write pointer
`timescale 1ns/1ps
`include "fifo_rd_regs.svh"
module tb;
  localparam int DL = 4;
  logic              ref_clk_in = 1'b0;
  logic              rst_n_in = 1'b0;
  logic              mrs_n = 1'b0, prs_n = 1'b1, first_word_fallthrough_mode = 1'b0, async_rd = 1'b0;
  logic [1:0]        width = 2'h0;
  logic              rclk = 1'b0, ren_n = 1'b0, rsel_n = 1'b0, oe_n = 1'b0;
  logic              rew_n = 1'b1, mark = 1'b0, ld_n = 1'b1, sclk = 1'b0;
  logic              sen_n = 1'b1, sdi = 1'b0, ready = 1'b0, push = 1'b0;
  logic [`DATA_W-1:0] pdata = '0, mdata, rdata, oe;
  logic [DL-1:0]     wptr, rptr, p;
  logic              wclr, valid, empty_n, first_word_fallthrough_mode_o;
  int                miscompares = 0, checks_done = 0;
  // 200 MHz clock
  always #2.5 ref_clk_in = ~ref_clk_in;
  fifo_read_port #(.DEPTH_LOG2(DL)) dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .master_reset_n_in(mrs_n), .partial_reset_n_in(prs_n),
    .first_word_fallthrough_mode_in(first_word_fallthrough_mode), .out_width_in(width), .async_read_in(async_rd),
    .read_clk_in(rclk), .read_enable_n_in(ren_n), .read_select_n_in(rsel_n),
    .output_enable_n_in(oe_n), .rewind_n_in(rew_n), .mark_in(mark),
    .offset_access_n_in(ld_n), .serial_clk_in(sclk), .serial_load_enable_n_in(sen_n),
    .serial_in(sdi), .mem_data_in(mdata), .write_ptr_in(wptr), .read_ptr_out(rptr),
    .write_ptr_clear_out(wclr), .data_ready_in(ready), .data_valid_out(valid),
    .read_data_out(rdata), .read_data_oe_out(oe), .empty_flag_n_out(empty_n),
    .first_word_fallthrough_mode_mode_out(first_word_fallthrough_mode_o));
  word_store_model #(.DEPTH_LOG2(DL)) mem (.ref_clk_in(ref_clk_in), .clear_in(wclr),
    .push_in(push), .push_data_in(pdata), .read_ptr_in(rptr), .mem_data_out(mdata),
    .write_ptr_out(wptr));
  task automatic chk36(input logic [`DATA_W-1:0] got, input logic [`DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk4(input logic [DL-1:0] got, input logic [DL-1:0] exp);
    chk36({{(`DATA_W-DL){1'b0}}, got}, {{(`DATA_W-DL){1'b0}}, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic master_reset_n(input logic [1:0] w, input logic a, input logic f);
    @(negedge ref_clk_in) mrs_n = 1'b0;
    width = w; async_rd = a; first_word_fallthrough_mode = f;
    tick(6); mrs_n = 1'b1; tick(6);
  endtask
  task automatic partial_reset_n();
    @(negedge ref_clk_in) prs_n = 1'b0;
    rsel_n = 1'b1; tick(6);
    chk36(oe, {`DATA_W{1'b1}}); // driven though select is high
    prs_n = 1'b1; rsel_n = 1'b0; tick(6);
  endtask
  task automatic push_word(input logic [`DATA_W-1:0] d);
    @(negedge ref_clk_in) push = 1'b1;
    pdata = d;
    @(negedge ref_clk_in) push = 1'b0;
  endtask
  // read clock or strobe held 3 cycles high and 3 low
  task automatic rd();
    @(negedge ref_clk_in) rclk = 1'b1;
    tick(3); rclk = 1'b0; tick(3);
  endtask
  // ready is raised only here, so every word stands until it is taken
  task automatic pop(input logic [`DATA_W-1:0] exp);
    logic [`DATA_W-1:0] got;
    got = ~exp;
    for (int i = 0; i < 20; i++) begin
      @(negedge ref_clk_in);
      if (valid === 1'b1) begin
        got = rdata;
        break;
      end
    end
    ready = 1'b1;
    @(negedge ref_clk_in) ready = 1'b0;
    chk36(got, exp);
  endtask
  task automatic shift_offsets(input logic [2*`OFFSET_W-1:0] v);
    sen_n = 1'b0;
    for (int i = 0; i < 2*`OFFSET_W; i++) begin
      sdi = v[2*`OFFSET_W-1-i]; sclk = 1'b1; tick(3); sclk = 1'b0; tick(3);
    end
    sen_n = 1'b1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    tick(12); rst_n_in = 1'b1;
    master_reset_n(2'h0, 1'b0, 1'b0);
    chk4(rptr, 0); chk36({35'h0, empty_n}, 36'h0); chk36({35'h0, first_word_fallthrough_mode_o}, 36'h0);
    $display("test reset done");
    // one push, read and pop per word; 18 words pass the wrap point
    for (int i = 0; i < 18; i++) begin
      push_word(36'h912345600 + i);
      if (i == 0) begin
        tick(1);
        chk36({35'h0, empty_n}, 36'h1);
      end
      rd(); pop(36'h912345600 + i);
      chk4(rptr, DL'(i + 1));
    end
    rd(); chk4(rptr, 4'h2); // empty read refused
    push_word(36'hA00000001); push_word(36'hA00000002); push_word(36'hA00000003);
    rd(); rd(); rd(); chk4(rptr, 4'h4); // third refused while both entries held
    pop(36'hA00000001); pop(36'hA00000002); rd(); pop(36'hA00000003);
    rsel_n = 1'b1; push_word(36'hB00000001); rd(); chk4(rptr, 4'h5);
    chk36(oe, 36'h0);
    rsel_n = 1'b0; rd(); pop(36'hB00000001);
    $display("test reads done");
    p = rptr; mark = 1'b1; tick(3); mark = 1'b0;
    push_word(36'hC00000001); push_word(36'hC00000002);
    rd(); pop(36'hC00000001); rd(); pop(36'hC00000002);
    rew_n = 1'b0; rd(); rew_n = 1'b1; chk4(rptr, p);
    rd(); pop(36'hC00000001);
    partial_reset_n(); chk4(rptr, 0); chk4(wptr, 0); chk36(rdata, 36'h0);
    push_word(36'hD00000001); rd(); pop(36'hD00000001);
    rew_n = 1'b0; rd(); rew_n = 1'b1; chk4(rptr, 0); chk4(wptr, 4'h1);
    $display("test rewind done");
    ld_n = 1'b0; rd(); pop({18'h0, `OFFSET_EMPTY_RST}); rd(); pop({18'h0, `OFFSET_FULL_RST});
    ld_n = 1'b1; shift_offsets({18'h2A0F3, 18'h00155}); partial_reset_n(); ld_n = 1'b0;
    rd(); pop(36'h000000155); rd(); pop(36'h00002A0F3); ld_n = 1'b1;
    $display("test offsets done");
    // narrow widths; the asynchronous strobe pass keeps enable low
    for (int i = 0; i < 2; i++) begin
      master_reset_n(2'(i + 1), 1'(i), 1'(1 - i));
      chk36({35'h0, first_word_fallthrough_mode_o}, {35'h0, 1'(1 - i)});
      push_word(36'hF5A5A5A5A); rd();
      pop(i ? 36'h05A : 36'h25A5A); chk36(oe, i ? 36'h1FF : 36'h3FFFF);
    end
    $display("test widths done");
    tally_and_finish();
  end
endmodule
